// >>> rtl/uamc_pkg.sv
package uamc_pkg;
  // Register bus shape
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MDM_SET = 8'h04;
  localparam logic [7:0] OFS_MDM_CLR = 8'h08;
  localparam logic [7:0] OFS_MDM_STAT = 8'h0c;
  localparam logic [7:0] OFS_RXERR = 8'h10;
  localparam logic [7:0] OFS_TXSTAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_RAW = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // Control register fields
  localparam int CTRL_TXHS_BIT = 0;
  localparam int CTRL_RXHS_BIT = 1;
  localparam int CTRL_SMART_BIT = 2;
  localparam int CTRL_TXIM_BIT = 3;
  localparam int CTRL_PAR_LSB = 4;
  localparam int CTRL_WLEN_LSB = 8;
  localparam int CTRL_TXTHR_LSB = 16;

  // Modem control and status bit positions
  localparam int MDM_DTR = 0;
  localparam int MDM_RTS = 1;
  localparam int MST_RI = 0;
  localparam int MST_DCD = 1;
  localparam int MST_DSR = 2;
  localparam int MST_CTS = 3;

  // Receiver error flag positions
  localparam int ERR_FE = 0;
  localparam int ERR_PE = 1;
  localparam int ERR_BE = 2;
  localparam int ERR_OE = 3;

  // Transmit status bits
  localparam int TXS_SPACE = 0;
  localparam int TXS_IDLE = 1;

  // Interrupt source positions
  localparam int IRQ_N = 11;
  localparam int IRQ_OE = 0;
  localparam int IRQ_BE = 1;
  localparam int IRQ_PE = 2;
  localparam int IRQ_FE = 3;
  localparam int IRQ_RT = 4;
  localparam int IRQ_TX = 5;
  localparam int IRQ_RX = 6;
  localparam int IRQ_DSR = 7;
  localparam int IRQ_DCD = 8;
  localparam int IRQ_CTS = 9;
  localparam int IRQ_RI = 10;

  // Word length codes
  localparam logic [1:0] WLEN_5 = 2'h0;
  localparam logic [1:0] WLEN_8 = 2'h3;

  // Parity selection
  typedef enum logic [2:0] {
    parity_off = 3'h0,
    parity_even_sel = 3'h1,
    parity_odd_sel = 3'h2,
    parity_stick_high = 3'h3,
    parity_stick_low = 3'h4
  } uamc_par_t;
endpackage

// >>> rtl/uamc_parity.sv
`timescale 1ns/1ps
module uamc_parity #(
  parameter int unsigned DW = 8
) (
  input wire logic [DW-1:0] i_data,
  input wire uamc_pkg::uamc_par_t i_mode,
  output logic o_par_bit,
  output logic o_par_used
);
  wire data_xor = ^i_data;

  // Expected parity bit; stick modes ignore the data entirely
  assign o_par_bit = (i_mode == uamc_pkg::parity_even_sel) ? data_xor :
                     (i_mode == uamc_pkg::parity_odd_sel) ? ~data_xor :
                     (i_mode == uamc_pkg::parity_stick_high);
  assign o_par_used = (i_mode != uamc_pkg::parity_off);
endmodule

// >>> rtl/uamc_ctrl.sv
`timescale 1ns/1ps
module uamc_ctrl #(
  parameter int unsigned TXLVL_W = 5,
  parameter int unsigned DW = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_ri,
  input wire logic i_dcd,
  input wire logic i_dsr,
  input wire logic i_cts,
  output logic o_dtr,
  output logic o_rts,
  output logic o_tx_allow,
  output logic [2:0] o_par_mode,
  output logic [1:0] o_wlen,
  output logic o_smart_en,
  input wire logic i_tx_load,
  input wire logic [DW-1:0] i_tx_data,
  output logic o_tx_par_bit,
  output logic o_tx_par_en,
  input wire logic i_rx_frame,
  input wire logic [DW-1:0] i_rx_data,
  input wire logic i_rx_par_bit,
  output logic o_rx_par_err,
  input wire logic i_rx_pop,
  input wire logic [3:0] i_rx_pop_err,
  input wire logic i_rx_overrun,
  input wire logic i_rx_push,
  input wire logic i_rx_timeout,
  input wire logic i_rx_space,
  input wire logic [TXLVL_W-1:0] i_tx_level,
  input wire logic i_tx_full,
  input wire logic i_tx_empty,
  input wire logic i_tx_busy,
  output logic o_irq
);
  // Control state
  logic txhs_q;
  logic rxhs_q;
  logic smart_q;
  logic idle_mode_q;
  uamc_pkg::uamc_par_t par_q;
  logic [1:0] wlen_q;
  logic [TXLVL_W-1:0] txthr_q;
  logic dtr_q;
  logic rts_sw_q;
  logic rts_q;
  logic tx_allow_q;
  logic [3:0] rxerr_q;
  logic [3:0] rxerr_d;
  logic [uamc_pkg::IRQ_N-1:0] raw_q;
  logic [uamc_pkg::IRQ_N-1:0] raw_d;
  logic [uamc_pkg::IRQ_N-1:0] mask_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic [3:0] mdm_m_q;
  logic [3:0] mdm_s_q;
  logic [3:0] mdm_p_q;
  logic [TXLVL_W-1:0] lvl_p_q;
  logic idle_p_q;
  logic tx_par_bit_q;
  logic tx_par_en_q;
  logic rx_par_err_q;

  // Address decode
  wire sel_ctrl = (i_addr == uamc_pkg::OFS_CTRL);
  wire sel_mset = (i_addr == uamc_pkg::OFS_MDM_SET);
  wire sel_mclr = (i_addr == uamc_pkg::OFS_MDM_CLR);
  wire sel_mst = (i_addr == uamc_pkg::OFS_MDM_STAT);
  wire sel_rxerr = (i_addr == uamc_pkg::OFS_RXERR);
  wire sel_txst = (i_addr == uamc_pkg::OFS_TXSTAT);
  wire sel_raw = (i_addr == uamc_pkg::OFS_IRQ_RAW);
  wire sel_mask = (i_addr == uamc_pkg::OFS_IRQ_MASK);
  wire wr_ctrl = i_wr && sel_ctrl;
  wire wr_mset = i_wr && sel_mset;
  wire wr_mclr = i_wr && sel_mclr;
  wire wr_rxerr = i_wr && sel_rxerr;
  wire wr_raw = i_wr && sel_raw;
  wire wr_mask = i_wr && sel_mask;

  // Control field decode; smart card forces the frame format whatever software wrote
  wire [2:0] par_wr_raw = i_wdata[uamc_pkg::CTRL_PAR_LSB +: 3];
  wire par_wr_ok = (par_wr_raw <= 3'(uamc_pkg::parity_stick_low));
  wire smart_wr = i_wdata[uamc_pkg::CTRL_SMART_BIT];
  wire [2:0] par_wr_code = smart_wr ? 3'(uamc_pkg::parity_even_sel) :
                           (par_wr_ok ? par_wr_raw : 3'(uamc_pkg::parity_off));
  wire uamc_pkg::uamc_par_t par_wr = uamc_pkg::uamc_par_t'(par_wr_code);
  wire [1:0] wlen_wr = smart_wr ? uamc_pkg::WLEN_8 : i_wdata[uamc_pkg::CTRL_WLEN_LSB +: 2];

  // Modem output update, masked set and clear
  wire dtr_d = wr_mset && i_wdata[uamc_pkg::MDM_DTR] ? 1'b1 :
               wr_mclr && i_wdata[uamc_pkg::MDM_DTR] ? 1'b0 : dtr_q;
  wire rts_sw_d = wr_mset && i_wdata[uamc_pkg::MDM_RTS] ? 1'b1 :
                  wr_mclr && i_wdata[uamc_pkg::MDM_RTS] ? 1'b0 : rts_sw_q;
  wire rts_d = rxhs_q ? i_rx_space : rts_sw_q;
  wire cts_s = mdm_s_q[uamc_pkg::MST_CTS];
  wire tx_allow_d = !txhs_q || cts_s;

  // Receiver error latching; a new error wins over a clear in the same cycle
  wire [3:0] pop_err = i_rx_pop ? i_rx_pop_err : 4'h0;
  wire [3:0] ovr_err = {3'h0, i_rx_overrun} << uamc_pkg::ERR_OE;
  wire [3:0] err_set = pop_err | ovr_err;
  wire [3:0] err_rise = err_set & ~rxerr_q;
  assign rxerr_d = (wr_rxerr ? 4'h0 : rxerr_q) | err_set;

  // Transmit interrupt events
  wire tx_idle = i_tx_empty && !i_tx_busy;
  wire tx_ev_idle = tx_idle && !idle_p_q;
  wire tx_ev_lvl = (lvl_p_q > txthr_q) && (i_tx_level <= txthr_q);
  wire tx_ev = idle_mode_q ? tx_ev_idle : tx_ev_lvl;

  // Modem line changes seen only on the synchronised copy
  wire [3:0] mdm_chg = mdm_s_q ^ mdm_p_q;

  // Interrupt sources; hardware set wins over write-one-to-clear
  wire [uamc_pkg::IRQ_N-1:0] ev = {mdm_chg[uamc_pkg::MST_RI], mdm_chg[uamc_pkg::MST_CTS],
                                   mdm_chg[uamc_pkg::MST_DCD], mdm_chg[uamc_pkg::MST_DSR],
                                   i_rx_push, tx_ev, i_rx_timeout,
                                   err_rise[uamc_pkg::ERR_FE], err_rise[uamc_pkg::ERR_PE],
                                   err_rise[uamc_pkg::ERR_BE], err_rise[uamc_pkg::ERR_OE]};
  wire [uamc_pkg::IRQ_N-1:0] raw_clr = wr_raw ? i_wdata[uamc_pkg::IRQ_N-1:0] : '0;
  assign raw_d = (raw_q & ~raw_clr) | ev;
  wire irq_d = |(raw_d & mask_q);

  // Read data selection; unmapped offsets read as zero
  wire [31:0] rd_ctrl = (32'(txthr_q) << uamc_pkg::CTRL_TXTHR_LSB) |
                        (32'(wlen_q) << uamc_pkg::CTRL_WLEN_LSB) |
                        (32'(par_q) << uamc_pkg::CTRL_PAR_LSB) |
                        (32'(idle_mode_q) << uamc_pkg::CTRL_TXIM_BIT) |
                        (32'(smart_q) << uamc_pkg::CTRL_SMART_BIT) |
                        (32'(rxhs_q) << uamc_pkg::CTRL_RXHS_BIT) |
                        (32'(txhs_q) << uamc_pkg::CTRL_TXHS_BIT);
  wire [31:0] rd_mdm = (32'(rts_q) << uamc_pkg::MDM_RTS) | (32'(dtr_q) << uamc_pkg::MDM_DTR);
  wire [31:0] rd_mst = 32'(mdm_s_q);
  wire [31:0] rd_txst = (32'(!i_tx_full) << uamc_pkg::TXS_SPACE) |
                        (32'(tx_idle) << uamc_pkg::TXS_IDLE);
  wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
                       (sel_mset || sel_mclr) ? rd_mdm :
                       sel_mst ? rd_mst :
                       sel_rxerr ? 32'(rxerr_q) :
                       sel_txst ? rd_txst :
                       sel_raw ? 32'(raw_q) :
                       sel_mask ? 32'(mask_q) : 32'h0;

  // Parity generation on transmit and checking on receive share one setting
  wire tx_par_exp;
  wire tx_par_used;
  wire rx_par_exp;
  wire rx_par_used;
  uamc_parity #(.DW(DW)) u_tx_par (
    .i_data(i_tx_data),
    .i_mode(par_q),
    .o_par_bit(tx_par_exp),
    .o_par_used(tx_par_used)
  );
  uamc_parity #(.DW(DW)) u_rx_par (
    .i_data(i_rx_data),
    .i_mode(par_q),
    .o_par_bit(rx_par_exp),
    .o_par_used(rx_par_used)
  );
  wire rx_par_bad = i_rx_frame && rx_par_used && (i_rx_par_bit != rx_par_exp);
  wire tx_par_bit_d = i_tx_load ? tx_par_exp : tx_par_bit_q;

  // Modem inputs are asynchronous: two flops before any use
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mdm_m_q <= 4'h0;
      mdm_s_q <= 4'h0;
      mdm_p_q <= 4'h0;
    end else begin
      mdm_m_q <= {i_cts, i_dsr, i_dcd, i_ri};
      mdm_s_q <= mdm_m_q;
      mdm_p_q <= mdm_s_q;
    end
  end

  // Configuration written by software
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      txhs_q <= 1'b0;
      rxhs_q <= 1'b0;
      smart_q <= 1'b0;
      idle_mode_q <= 1'b0;
      par_q <= uamc_pkg::parity_off;
      wlen_q <= uamc_pkg::WLEN_5;
      txthr_q <= '0;
    end else if (wr_ctrl) begin
      txhs_q <= i_wdata[uamc_pkg::CTRL_TXHS_BIT];
      rxhs_q <= i_wdata[uamc_pkg::CTRL_RXHS_BIT];
      smart_q <= smart_wr;
      idle_mode_q <= i_wdata[uamc_pkg::CTRL_TXIM_BIT];
      par_q <= par_wr;
      wlen_q <= wlen_wr;
      txthr_q <= i_wdata[uamc_pkg::CTRL_TXTHR_LSB +: TXLVL_W];
    end
  end

  // Modem outputs and transmit gate
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dtr_q <= 1'b0;
      rts_sw_q <= 1'b0;
      rts_q <= 1'b0;
      tx_allow_q <= 1'b1;
    end else begin
      dtr_q <= dtr_d;
      rts_sw_q <= rts_sw_d;
      rts_q <= rts_d;
      tx_allow_q <= tx_allow_d;
    end
  end

  // Error flags, interrupt state and history for edge detection
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rxerr_q <= 4'h0;
      raw_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      lvl_p_q <= '0;
      idle_p_q <= 1'b1;
    end else begin
      rxerr_q <= rxerr_d;
      raw_q <= raw_d;
      mask_q <= wr_mask ? i_wdata[uamc_pkg::IRQ_N-1:0] : mask_q;
      irq_q <= irq_d;
      lvl_p_q <= i_tx_level;
      idle_p_q <= tx_idle;
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= i_rd ? rd_mux : 32'h0;
    end
  end

  // Parity toward the shifters
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_par_bit_q <= 1'b0;
      tx_par_en_q <= 1'b0;
      rx_par_err_q <= 1'b0;
    end else begin
      tx_par_bit_q <= tx_par_bit_d;
      tx_par_en_q <= tx_par_used;
      rx_par_err_q <= rx_par_bad;
    end
  end

  assign o_rdata = rdata_q;
  assign o_dtr = dtr_q;
  assign o_rts = rts_q;
  assign o_tx_allow = tx_allow_q;
  assign o_par_mode = par_q;
  assign o_wlen = wlen_q;
  assign o_smart_en = smart_q;
  assign o_tx_par_bit = tx_par_bit_q;
  assign o_tx_par_en = tx_par_en_q;
  assign o_rx_par_err = rx_par_err_q;
  assign o_irq = irq_q;

  // Checks, all on the one clock
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_dtr_set_clear: assert property (wr_mset && i_wdata[uamc_pkg::MDM_DTR] |=> o_dtr ##1 (o_dtr || $past(wr_mclr)))
    else $error("DTR did not assert after a set write");
  a_modem_stat_read: assert property (i_rd && sel_mst |=> o_rdata[3:0] == $past(mdm_s_q))
    else $error("Modem status read differs from synchronised lines");
  a_par_enable: assert property (par_q != uamc_pkg::parity_off |=> o_tx_par_en)
    else $error("Parity enable low while a parity mode is set");
  a_stick_high_bit: assert property (i_tx_load && par_q == uamc_pkg::parity_stick_high |=> o_tx_par_bit)
    else $error("Stick high parity bit not one");
  a_stick_low_check: assert property (i_rx_frame && par_q == uamc_pkg::parity_stick_low && i_rx_par_bit
                                      |=> o_rx_par_err)
    else $error("Stick low parity mismatch not flagged");
  a_err_flag_hold: assert property (!wr_rxerr |=> (rxerr_q & $past(rxerr_q)) == $past(rxerr_q))
    else $error("Receiver error flag dropped without a clear");
  a_pop_err_copy: assert property (i_rx_pop |=> (rxerr_q & $past(i_rx_pop_err)) == $past(i_rx_pop_err))
    else $error("Character error bits not reflected in flags");
  a_ovr_immediate: assert property (i_rx_overrun |=> rxerr_q[uamc_pkg::ERR_OE])
    else $error("Overrun flag not set at once");
  a_err_clear_all: assert property (wr_rxerr && err_set == 4'h0 |=> rxerr_q == 4'h0)
    else $error("Error clear left a flag set");
  a_err_irq_once: assert property (rxerr_q[uamc_pkg::ERR_FE] && !raw_q[uamc_pkg::IRQ_FE] && !wr_rxerr
                                   |=> !raw_q[uamc_pkg::IRQ_FE])
    else $error("Latched framing error raised a repeat interrupt");
  a_smart_format: assert property (wr_ctrl && smart_wr
                                   |=> par_q == uamc_pkg::parity_even_sel && wlen_q == uamc_pkg::WLEN_8)
    else $error("Smart card write did not force 8 bits even parity");
  a_space_status: assert property (i_rd && sel_txst |=> o_rdata[uamc_pkg::TXS_SPACE] == !$past(i_tx_full))
    else $error("Transmit space status wrong");
  a_txirq_level: assert property (!idle_mode_q && lvl_p_q > txthr_q && i_tx_level <= txthr_q
                                  |=> raw_q[uamc_pkg::IRQ_TX])
    else $error("Level transmit interrupt missed");
  a_txirq_idle: assert property (idle_mode_q && tx_idle && !idle_p_q |=> raw_q[uamc_pkg::IRQ_TX])
    else $error("End of transmission interrupt missed");
  a_txirq_idle_quiet: assert property (idle_mode_q && !tx_ev_idle && !raw_q[uamc_pkg::IRQ_TX] |=> !raw_q[uamc_pkg::IRQ_TX])
    else $error("Transmit interrupt raised in idle mode without an idle edge");
  a_mask_keeps_rts: assert property (wr_mset && !i_wdata[uamc_pkg::MDM_RTS] |=> rts_sw_q == $past(rts_sw_q))
    else $error("Modem set changed an unselected output");
  a_cts_gate: assert property (txhs_q && !cts_s |=> !o_tx_allow)
    else $error("Transmit allowed while CTS is low");
  a_rts_hw: assert property (rxhs_q |=> o_rts == $past(i_rx_space))
    else $error("RTS does not follow receive space");
  a_irq_level: assert property (|(raw_q & mask_q) && !wr_raw |=> o_irq)
    else $error("Interrupt output low with unmasked status set");

  c_overrun: cover property (i_rx_overrun ##1 rxerr_q[uamc_pkg::ERR_OE] ##[1:20] wr_rxerr);
  c_smart: cover property (wr_ctrl && smart_wr);
  c_tx_idle_irq: cover property (idle_mode_q && tx_ev_idle ##1 o_irq);
  c_rts_hw: cover property (rxhs_q && !i_rx_space ##1 !o_rts);
  c_err_rearm: cover property (wr_rxerr ##1 i_rx_overrun ##1 raw_q[uamc_pkg::IRQ_OE]);
endmodule

// >>> verif/uamc_remote.sv
`timescale 1ns/1ps
// Far-end modem: drives RI, DCD, DSR and CTS as plain levels
module uamc_remote (
  input wire logic i_ref_clk,
  input wire logic [3:0] i_lines,
  input wire logic i_slow,
  output logic o_ri,
  output logic o_dcd,
  output logic o_dsr,
  output logic o_cts
);
  logic [3:0] dly_q [0:2];
  logic [3:0] now_lines;
  // A slow modem answers three clocks late, so the sync path sees late edges too
  always_ff @(posedge i_ref_clk) begin
    dly_q[0] <= i_lines;
    dly_q[1] <= dly_q[0];
    dly_q[2] <= dly_q[1];
  end
  // Lines are levels and never released, so no idle pattern is needed
  assign now_lines = i_slow ? dly_q[2] : i_lines;
  assign o_ri = now_lines[0];
  assign o_dcd = now_lines[1];
  assign o_dsr = now_lines[2];
  assign o_cts = now_lines[3];
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_ref_clk, i_rst, i_wr, i_rd, i_tx_load, i_rx_frame, i_rx_par_bit, i_rx_pop, i_rx_overrun;
  logic i_rx_push, i_rx_timeout, i_rx_space, i_tx_full, i_tx_empty, i_tx_busy, slow, rd_seen;
  logic ri, dcd, dsr, cts, o_dtr, o_rts, o_tx_allow, o_smart_en, o_tx_par_bit, o_tx_par_en;
  logic o_rx_par_err, o_irq, fl, pb;
  logic [7:0] i_addr, i_tx_data, i_rx_data, d;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_rx_pop_err, lines, v;
  logic [4:0] i_tx_level;
  logic [2:0] o_par_mode, pm;
  logic [1:0] o_wlen;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int checks_done = 0;

  uamc_ctrl #(.TXLVL_W(5), .DW(8)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ri(ri), .i_dcd(dcd),
    .i_dsr(dsr), .i_cts(cts), .o_dtr(o_dtr), .o_rts(o_rts), .o_tx_allow(o_tx_allow),
    .o_par_mode(o_par_mode), .o_wlen(o_wlen), .o_smart_en(o_smart_en), .i_tx_load(i_tx_load),
    .i_tx_data(i_tx_data), .o_tx_par_bit(o_tx_par_bit), .o_tx_par_en(o_tx_par_en),
    .i_rx_frame(i_rx_frame), .i_rx_data(i_rx_data), .i_rx_par_bit(i_rx_par_bit),
    .o_rx_par_err(o_rx_par_err), .i_rx_pop(i_rx_pop), .i_rx_pop_err(i_rx_pop_err),
    .i_rx_overrun(i_rx_overrun), .i_rx_push(i_rx_push), .i_rx_timeout(i_rx_timeout),
    .i_rx_space(i_rx_space), .i_tx_level(i_tx_level), .i_tx_full(i_tx_full),
    .i_tx_empty(i_tx_empty), .i_tx_busy(i_tx_busy), .o_irq(o_irq));
  uamc_remote modem (.i_ref_clk(i_ref_clk), .i_lines(lines), .i_slow(slow), .o_ri(ri), .o_dcd(dcd),
    .o_dsr(dsr), .o_cts(cts));

  // 20 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // Checks are made mid-cycle so every edge update has landed
  task automatic settle;
    @(negedge i_ref_clk);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles leave one idle cycle so a strobe is never driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    i_addr <= a;
    i_wdata <= dat;
    i_wr <= 1'b1;
    tick(1);
    i_wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    tick(1);
    i_rd <= 1'b0;
    tick(1);
  endtask
  task automatic ovr;
    i_rx_overrun <= 1'b1;
    tick(1);
    i_rx_overrun <= 1'b0;
    tick(1);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there
  always @(posedge i_ref_clk) rd_seen <= i_rd;
  always @(negedge i_ref_clk) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) cmp(32'hdead, 32'h0);
      else cmp(o_rdata, exp_q.pop_front());
    end
  end

  // Watchdog sized well above the few hundred cycles the sequence needs
  initial begin
    tick(20000);
    error_cnt++;
    conclude();
  end

  initial begin
    i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00; i_wdata = 32'h0; i_tx_load = 1'b0;
    i_tx_data = 8'h00; i_rx_frame = 1'b0; i_rx_data = 8'h00; i_rx_par_bit = 1'b0; i_rx_pop = 1'b0;
    i_rx_pop_err = 4'h0; i_rx_overrun = 1'b0; i_rx_push = 1'b0; i_rx_timeout = 1'b0; i_rx_space = 1'b1;
    i_tx_level = 5'h00; i_tx_full = 1'b0; i_tx_empty = 1'b1; i_tx_busy = 1'b0; lines = 4'h0;
    slow = 1'b0;
    void'($urandom(25));
    tick(16);
    i_rst <= 1'b0;
    tick(1);
    // Reset state and refused offsets
    rd(uamc_pkg::OFS_CTRL, 32'h0);
    rd(uamc_pkg::OFS_MDM_SET, 32'h0);
    rd(uamc_pkg::OFS_RXERR, 32'h0);
    wr(8'h24, 32'hffffffff);
    rd(8'h24, 32'h0);
    settle;
    cmp(o_tx_allow, 1'b1);
    cmp(o_irq, 1'b0);
    tick(1);
    // Modem outputs: set and clear touch only masked bits
    wr(uamc_pkg::OFS_MDM_SET, 32'h1);
    settle;
    cmp({o_rts, o_dtr}, 2'h1);
    tick(1);
    wr(uamc_pkg::OFS_MDM_SET, 32'h2);
    wr(uamc_pkg::OFS_MDM_CLR, 32'h1);
    rd(uamc_pkg::OFS_MDM_CLR, 32'h2);
    settle;
    cmp({o_rts, o_dtr}, 2'h2);
    tick(1);
    // Random modem line states, prompt and slow far end
    for (int k = 0; k < 4; k++) begin
      v = 4'($urandom);
      slow <= k[0];
      lines <= v;
      tick(6);
      rd(uamc_pkg::OFS_MDM_STAT, {28'h0, v});
    end
    // Every parity code, plus an illegal one stored as off
    for (int m = 0; m < 6; m++) begin
      d = 8'($urandom);
      fl = (m == 4) ? 1'b1 : 1'($urandom);
      pm = (m > 4) ? 3'h0 : 3'(m);
      case (pm)
        3'h1: pb = ^d;
        3'h2: pb = ~^d;
        3'h3: pb = 1'b1;
        default: pb = 1'b0;
      endcase
      wr(uamc_pkg::OFS_CTRL, (32'(m) << 4) | 32'h300);
      i_tx_load <= 1'b1;
      i_tx_data <= d;
      i_rx_frame <= 1'b1;
      i_rx_data <= d;
      i_rx_par_bit <= pb ^ fl;
      tick(1);
      i_tx_load <= 1'b0;
      i_rx_frame <= 1'b0;
      settle;
      cmp(o_par_mode, pm);
      cmp(o_tx_par_en, pm != 3'h0);
      if (pm != 3'h0) cmp(o_tx_par_bit, pb);
      cmp(o_rx_par_err, (pm != 3'h0) && fl);
      tick(1);
    end
    // Smart card enable forces 8-bit even parity
    wr(uamc_pkg::OFS_CTRL, 32'h4);
    rd(uamc_pkg::OFS_CTRL, 32'h314);
    settle;
    cmp({o_smart_en, o_par_mode, o_wlen}, {1'b1, 3'h1, 2'h3});
    tick(1);
    // Handshakes: CTS gates transmit, receive space drives RTS
    wr(uamc_pkg::OFS_CTRL, 32'h1);
    lines <= 4'h0;
    tick(8);
    settle;
    cmp(o_tx_allow, 1'b0);
    tick(1);
    lines <= 4'h8;
    tick(8);
    settle;
    cmp(o_tx_allow, 1'b1);
    tick(1);
    wr(uamc_pkg::OFS_CTRL, 32'h2);
    i_rx_space <= 1'b0;
    tick(3);
    rd(uamc_pkg::OFS_MDM_SET, 32'h0);
    i_rx_space <= 1'b1;
    tick(3);
    rd(uamc_pkg::OFS_MDM_SET, 32'h2);
    // Error flags, overrun timing, clear order and the error interrupt
    wr(uamc_pkg::OFS_CTRL, 32'h0);
    wr(uamc_pkg::OFS_RXERR, 32'h0);
    wr(uamc_pkg::OFS_IRQ_RAW, 32'h7ff);
    wr(uamc_pkg::OFS_IRQ_MASK, 32'h1);
    i_rx_pop <= 1'b1;
    i_rx_pop_err <= 4'h5;
    tick(1);
    i_rx_pop <= 1'b0;
    rd(uamc_pkg::OFS_RXERR, 32'h5);
    ovr();
    rd(uamc_pkg::OFS_RXERR, 32'hd);
    settle;
    cmp(o_irq, 1'b1);
    tick(1);
    wr(uamc_pkg::OFS_IRQ_RAW, 32'h9);
    settle;
    cmp(o_irq, 1'b0);
    tick(1);
    ovr();
    tick(1);
    settle;
    cmp(o_irq, 1'b0);
    tick(1);
    wr(uamc_pkg::OFS_RXERR, 32'h0);
    rd(uamc_pkg::OFS_RXERR, 32'h0);
    ovr();
    settle;
    cmp(o_irq, 1'b1);
    tick(1);
    // Transmit interrupt: level threshold boundary, then end of transmission
    wr(uamc_pkg::OFS_IRQ_MASK, 32'h20);
    i_tx_level <= 5'h06;
    wr(uamc_pkg::OFS_CTRL, 32'h40000);
    wr(uamc_pkg::OFS_IRQ_RAW, 32'h7ff);
    i_tx_level <= 5'h05;
    tick(3);
    settle;
    cmp(o_irq, 1'b0);
    tick(1);
    i_tx_level <= 5'h04;
    tick(3);
    settle;
    cmp(o_irq, 1'b1);
    tick(1);
    i_tx_empty <= 1'b0;
    i_tx_busy <= 1'b1;
    wr(uamc_pkg::OFS_CTRL, 32'h40008);
    wr(uamc_pkg::OFS_IRQ_RAW, 32'h7ff);
    i_tx_empty <= 1'b1;
    tick(3);
    settle;
    cmp(o_irq, 1'b0);
    tick(1);
    rd(uamc_pkg::OFS_TXSTAT, 32'h1);
    i_tx_busy <= 1'b0;
    tick(3);
    settle;
    cmp(o_irq, 1'b1);
    tick(1);
    i_tx_full <= 1'b1;
    i_tx_empty <= 1'b0;
    tick(1);
    rd(uamc_pkg::OFS_TXSTAT, 32'h0);
    tick(2);
    conclude();
  end
endmodule
